/* logic/fsgtr_pkg.sv */
// Shared constants, opcodes and decode helpers of the sector guard and training registers
package fsgtr_pkg;

  // ********************************
  // Opcodes
  // ********************************
  localparam logic [7:0] SECRET_KEY_READ_CMD = 8'he7;
  localparam logic [7:0] SECRET_KEY_PROGRAM_CMD = 8'he8;
  localparam logic [7:0] GUARD_LOCK_READ_CMD = 8'ha7;
  localparam logic [7:0] GUARD_LOCK_WRITE_CMD = 8'ha6;
  localparam logic [7:0] PERSISTENT_GUARD_READ_CMD = 8'he2;
  localparam logic [7:0] PERSISTENT_GUARD_PROGRAM_CMD = 8'he3;
  localparam logic [7:0] PERSISTENT_GUARD_ERASE_CMD = 8'he4;
  localparam logic [7:0] DYNAMIC_GUARD_READ_CMD = 8'he0;
  localparam logic [7:0] DYNAMIC_GUARD_WRITE_CMD = 8'he1;
  localparam logic [7:0] STORED_PATTERN_PROGRAM_CMD = 8'h43;
  localparam logic [7:0] WORKING_PATTERN_WRITE_CMD = 8'h4a;
  localparam logic [7:0] TRAINING_PATTERN_READ_CMD = 8'h41;
  localparam logic [7:0] CONFIG_WORD_READ_CMD = 8'h2b;
  localparam logic [7:0] CONFIG_WORD_PROGRAM_CMD = 8'h2f;

  // ********************************
  // Fields, sizes and reset values
  // ********************************
  localparam int CFG_SECRET_BIT = 2;
  localparam int CFG_PERSIST_BIT = 1;
  localparam int LOCK_FLAG_BIT = 0;
  localparam int ADDR_BITS = 24;
  localparam int SECTOR_LSB = 16;
  localparam int SECTOR_BITS = 4;
  localparam int SECTORS = 16;
  localparam logic [15:0] CFG_RESET = 16'hffff;
  localparam logic [63:0] KEY_RESET = 64'hffff_ffff_ffff_ffff;
  localparam logic [7:0] PAT_RESET = 8'h00;
  localparam logic [15:0] GUARD_RESET = 16'hffff;
  localparam logic [7:0] ACCESS_OPEN = 8'hff;
  localparam logic [7:0] ACCESS_GUARDED = 8'h00;
  localparam logic [6:0] BITS_KEY = 7'h40;
  localparam logic [6:0] BITS_WORD = 7'h10;
  localparam logic [6:0] BITS_BYTE = 7'h08;
  localparam logic [6:0] BITS_NONE = 7'h00;

  typedef enum logic [2:0] {
    PH_CMD = 3'b000,
    PH_ADDR = 3'b001,
    PH_DIN = 3'b010,
    PH_DOUT = 3'b011,
    PH_DONE = 3'b100
  } fsgtr_phase_t;

  function automatic logic op_has_addr(input logic [7:0] op);
    return (op == PERSISTENT_GUARD_READ_CMD) || (op == PERSISTENT_GUARD_PROGRAM_CMD) ||
           (op == DYNAMIC_GUARD_READ_CMD) || (op == DYNAMIC_GUARD_WRITE_CMD);
  endfunction

  function automatic logic op_is_read(input logic [7:0] op);
    return (op == SECRET_KEY_READ_CMD) || (op == GUARD_LOCK_READ_CMD) ||
           (op == PERSISTENT_GUARD_READ_CMD) || (op == DYNAMIC_GUARD_READ_CMD) ||
           (op == TRAINING_PATTERN_READ_CMD) || (op == CONFIG_WORD_READ_CMD);
  endfunction

  function automatic logic [6:0] op_in_bits(input logic [7:0] op);
    logic [6:0] n;
    n = BITS_NONE;
    if (op == SECRET_KEY_PROGRAM_CMD) n = BITS_KEY;
    else if (op == CONFIG_WORD_PROGRAM_CMD) n = BITS_WORD;
    else if ((op == GUARD_LOCK_WRITE_CMD) || (op == DYNAMIC_GUARD_WRITE_CMD) ||
             (op == STORED_PATTERN_PROGRAM_CMD) || (op == WORKING_PATTERN_WRITE_CMD)) n = BITS_BYTE;
    return n;
  endfunction

  function automatic logic [SECTOR_BITS-1:0] sector_of(input logic [23:0] a);
    return a[SECTOR_LSB +: SECTOR_BITS];
  endfunction

endpackage

/* logic/fsgtr_sync.sv */
// Two flip-flop level synchroniser
`timescale 1ns/1ps
module fsgtr_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } fsgtr_sync_t;

  fsgtr_sync_t st;
  fsgtr_sync_t next_st;

  always_comb begin
    next_st.s1 = d;
    next_st.s2 = st.s1;
  end

  always_ff @(posedge clk) begin
    st <= next_st;
  end

  assign q = st.s2;
endmodule // fsgtr_sync

/* logic/fsgtr_regs.sv */
// Sector guard and training pattern registers behind the serial command link
`timescale 1ns/1ps
module fsgtr_regs
  import fsgtr_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic hw_rst_n,
  input wire logic sw_rst,
  input wire logic spi_clk,
  input wire logic cs_n,
  input wire logic si,
  output logic so,
  output logic so_oe,
  input wire logic ddr_dummy,
  output logic [3:0] train_rise,
  output logic [3:0] train_fall,
  output logic train_oe,
  output logic secret_key_mode,
  output logic persistent_mode,
  output logic guard_array_writable,
  output logic [SECTORS-1:0] sector_protect
);

  // ********************************
  // State types
  // ********************************
  typedef struct packed {
    logic [15:0] cfg;
    logic [63:0] key;
    logic [7:0] stored;
    logic stored_done;
    logic [7:0] working;
    logic lock;
    logic [SECTORS-1:0] pguard;
    logic [SECTORS-1:0] dguard;
    logic [15:0] s_cfg;
    logic [63:0] s_key;
    logic s_lock;
    logic [SECTORS-1:0] s_pguard;
    logic [SECTORS-1:0] s_dguard;
    logic [7:0] s_work;
    logic frozen;
    logic req_seen;
  } fsgtr_core_t;

  typedef struct packed {
    fsgtr_phase_t ph;
    logic [6:0] cnt;
    logic [7:0] op;
    logic [23:0] addr;
    logic [63:0] sh;
    logic so;
    logic so_en;
    logic [1:0] tk;
    logic [3:0] t_rise;
    logic [3:0] t_fall;
    logic t_en;
  } fsgtr_link_t;

  typedef struct packed {
    logic [7:0] op;
    logic [23:0] addr;
    logic [63:0] data;
    logic tog;
  } fsgtr_post_t;

  fsgtr_core_t c;
  fsgtr_core_t next_c;
  fsgtr_link_t l;
  fsgtr_link_t next_l;
  fsgtr_post_t p;
  fsgtr_post_t next_p;
  logic cs_s;
  logic req_s;
  logic hw_n_s;
  logic frozen_s;
  logic req_fire;
  logic vol_rst;
  logic [15:0] d16;
  logic load;
  logic fire;
  logic [63:0] word;
  logic [7:0] pat;

  // ********************************
  // Crossings
  // ********************************
  fsgtr_sync #(.WIDTH(3)) u_to_core (
    .clk(clk),
    .d({cs_n, p.tog, hw_rst_n}),
    .q({cs_s, req_s, hw_n_s})
  );

  fsgtr_sync #(.WIDTH(1)) u_to_link (
    .clk(spi_clk),
    .d(c.frozen),
    .q(frozen_s)
  );

  function automatic logic [63:0] read_word(input logic [7:0] op, input logic [23:0] a);
    logic [7:0] b;
    logic [63:0] w;
    b = 8'h00;
    w = KEY_RESET;
    if (op == GUARD_LOCK_READ_CMD) b = {7'h00, c.s_lock};
    else if (op == PERSISTENT_GUARD_READ_CMD) b = c.s_pguard[sector_of(a)] ? ACCESS_OPEN : ACCESS_GUARDED;
    else if (op == DYNAMIC_GUARD_READ_CMD) b = c.s_dguard[sector_of(a)] ? ACCESS_OPEN : ACCESS_GUARDED;
    else if (op == TRAINING_PATTERN_READ_CMD) b = c.s_work;
    if (!frozen_s) w = KEY_RESET;
    else if (op == SECRET_KEY_READ_CMD) w = c.s_key;
    else if (op == CONFIG_WORD_READ_CMD) w = {c.s_cfg, 48'h0000_0000_0000};
    else w = {b, 56'h00_0000_0000_0000};
    return w;
  endfunction

  // ********************************
  // Core registers
  // ********************************
  always_comb begin
    next_c = c;
    d16 = p.data[15:0];
    req_fire = req_s != c.req_seen;
    vol_rst = !hw_n_s || sw_rst;
    next_c.req_seen = req_s;
    next_c.frozen = !cs_s;
    if (cs_s) begin
      next_c.s_cfg = c.cfg;
      next_c.s_key = secret_key_mode ? KEY_RESET : c.key;
      next_c.s_lock = c.lock;
      next_c.s_pguard = c.pguard;
      next_c.s_dguard = c.dguard;
      next_c.s_work = c.working;
    end
    if (req_fire) begin
      case (p.op)
        SECRET_KEY_PROGRAM_CMD: begin
          if (!secret_key_mode) next_c.key = c.key & p.data;
        end
        GUARD_LOCK_WRITE_CMD: begin
          next_c.lock = c.lock & p.data[LOCK_FLAG_BIT];
        end
        PERSISTENT_GUARD_PROGRAM_CMD: begin
          if (c.lock) next_c.pguard[sector_of(p.addr)] = 1'b0;
        end
        PERSISTENT_GUARD_ERASE_CMD: begin
          if (c.lock) next_c.pguard = GUARD_RESET;
        end
        DYNAMIC_GUARD_WRITE_CMD: begin
          if (p.data[7:0] == ACCESS_OPEN) next_c.dguard[sector_of(p.addr)] = 1'b1;
          else if (p.data[7:0] == ACCESS_GUARDED) next_c.dguard[sector_of(p.addr)] = 1'b0;
        end
        STORED_PATTERN_PROGRAM_CMD: begin
          if (!c.stored_done) begin
            next_c.stored = p.data[7:0];
            next_c.stored_done = 1'b1;
            next_c.working = p.data[7:0];
          end
        end
        WORKING_PATTERN_WRITE_CMD: begin
          next_c.working = p.data[7:0];
        end
        CONFIG_WORD_PROGRAM_CMD: begin
          // Only one mode lock may ever reach zero
          if (!(c.cfg[CFG_SECRET_BIT] && c.cfg[CFG_PERSIST_BIT] &&
                (d16[CFG_SECRET_BIT] || d16[CFG_PERSIST_BIT]))) begin
            d16[CFG_SECRET_BIT] = 1'b1;
            d16[CFG_PERSIST_BIT] = 1'b1;
          end
          next_c.cfg = c.cfg & d16;
        end
        default: begin
        end
      endcase
    end
    if (vol_rst) begin
      next_c.working = c.stored;
      next_c.dguard = GUARD_RESET;
      if (!hw_n_s) next_c.lock = !secret_key_mode;
    end
    if (sys_rst) begin
      next_c = '0;
      next_c.cfg = CFG_RESET;
      next_c.key = KEY_RESET;
      next_c.stored = PAT_RESET;
      next_c.working = PAT_RESET;
      next_c.lock = 1'b1;
      next_c.pguard = GUARD_RESET;
      next_c.dguard = GUARD_RESET;
    end
  end

  always_ff @(posedge clk) begin
    c <= next_c;
  end

  assign secret_key_mode = !c.cfg[CFG_SECRET_BIT];
  assign persistent_mode = !c.cfg[CFG_PERSIST_BIT];
  assign guard_array_writable = c.lock;
  assign sector_protect = ~(c.pguard & c.dguard);

  // ********************************
  // Link command engine
  // ********************************
  always_comb begin
    next_l = l;
    next_p = p;
    load = 1'b0;
    fire = 1'b0;
    word = KEY_RESET;
    pat = c.s_work << {l.tk, 1'b0};
    case (l.ph)
      PH_CMD: begin
        next_l.op = {l.op[6:0], si};
        next_l.cnt = l.cnt + 7'h01;
        if (l.cnt == 7'h07) begin
          next_l.cnt = 7'h00;
          if (op_has_addr(next_l.op)) next_l.ph = PH_ADDR;
          else if (op_is_read(next_l.op)) load = 1'b1;
          else if (op_in_bits(next_l.op) != BITS_NONE) next_l.ph = PH_DIN;
          else begin
            fire = next_l.op == PERSISTENT_GUARD_ERASE_CMD;
            next_l.ph = PH_DONE;
          end
        end
      end
      PH_ADDR: begin
        next_l.addr = {l.addr[22:0], si};
        next_l.cnt = l.cnt + 7'h01;
        if (l.cnt == 7'(ADDR_BITS - 1)) begin
          next_l.cnt = 7'h00;
          if (op_is_read(l.op)) load = 1'b1;
          else if (op_in_bits(l.op) != BITS_NONE) next_l.ph = PH_DIN;
          else begin
            fire = 1'b1;
            next_l.ph = PH_DONE;
          end
        end
      end
      PH_DIN: begin
        next_l.sh = {l.sh[62:0], si};
        next_l.cnt = l.cnt + 7'h01;
        if (l.cnt == op_in_bits(l.op) - 7'h01) begin
          fire = 1'b1;
          next_l.ph = PH_DONE;
        end
      end
      PH_DOUT: begin
        next_l.so = l.sh[63];
        next_l.sh = {l.sh[62:0], 1'b0};
      end
      default: begin
      end
    endcase
    if (load) begin
      word = read_word(next_l.op, next_l.addr);
      next_l.ph = PH_DOUT;
      next_l.so = word[63];
      next_l.sh = {word[62:0], 1'b0};
      next_l.so_en = 1'b1;
    end
    if (fire) begin
      next_p.op = next_l.op;
      next_p.addr = next_l.addr;
      next_p.data = next_l.sh;
      next_p.tog = !p.tog;
    end
    // Training preamble, two bits per link cycle
    if (ddr_dummy && frozen_s && c.s_work != PAT_RESET) begin
      next_l.t_rise = {4{pat[7]}};
      next_l.t_fall = {4{pat[6]}};
      next_l.t_en = 1'b1;
      next_l.tk = l.tk + 2'h1;
    end else begin
      next_l.t_rise = 4'h0;
      next_l.t_fall = 4'h0;
      next_l.t_en = 1'b0;
      next_l.tk = 2'h0;
    end
  end

  // Frame state ends with chip select
  always_ff @(posedge spi_clk or posedge cs_n or posedge sys_rst) begin
    if (cs_n || sys_rst) begin
      l <= '0;
    end else begin
      l <= next_l;
    end
  end

  // Posted write survives the frame
  always_ff @(posedge spi_clk or posedge sys_rst) begin
    if (sys_rst) begin
      p <= '0;
    end else begin
      p <= next_p;
    end
  end

  assign so = l.so;
  assign so_oe = l.so_en;
  assign train_rise = l.t_rise;
  assign train_fall = l.t_fall;
  assign train_oe = l.t_en;

  // ********************************
  // Checks
  // ********************************
  a_secret_mode_sticky: assert property (@(posedge clk) disable iff (sys_rst)
    secret_key_mode |=> secret_key_mode) else $error("secret-key mode left");
  a_persist_mode_sticky: assert property (@(posedge clk) disable iff (sys_rst)
    persistent_mode |=> persistent_mode) else $error("persistent mode left");
  a_modes_exclusive: assert property (@(posedge clk) disable iff (sys_rst)
    !(secret_key_mode && persistent_mode)) else $error("both modes selected");
  a_key_hidden_snap: assert property (@(posedge clk) disable iff (sys_rst)
    (secret_key_mode && cs_s) |=> (c.s_key == KEY_RESET)) else $error("key visible");
  a_locked_array_frozen: assert property (@(posedge clk) disable iff (sys_rst)
    !c.lock |=> $stable(c.pguard)) else $error("guard array changed while locked");
  a_lock_rise_cause: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(c.lock) |-> !$past(hw_n_s)) else $error("lock reopened without hw reset");
  a_lock_byte_zero: assert property (@(posedge spi_clk) disable iff (cs_n || sys_rst)
    (l.ph == PH_CMD && l.cnt == 7'h07 && {l.op[6:0], si} == GUARD_LOCK_READ_CMD && frozen_s)
    |=> (!l.so && l.sh[63:58] == 6'h00)) else $error("reserved lock bits not zero");
  a_dguard_reset_open: assert property (@(posedge clk) disable iff (sys_rst)
    vol_rst |=> (c.dguard == GUARD_RESET)) else $error("dynamic guard not reset");
  a_stored_once: assert property (@(posedge clk) disable iff (sys_rst)
    c.stored_done |=> $stable(c.stored) && c.stored_done) else $error("stored pattern rewritten");
  a_stored_copy: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(c.stored_done) |-> (c.working == c.stored)) else $error("working not copied");
  a_working_reload: assert property (@(posedge clk) disable iff (sys_rst)
    vol_rst |=> (c.working == $past(c.stored))) else $error("working not reloaded");
  a_train_msb_first: assert property (@(posedge spi_clk) disable iff (cs_n || sys_rst)
    (ddr_dummy && frozen_s && l.tk == 2'h0 && c.s_work != PAT_RESET)
    |=> (train_rise == {4{$past(c.s_work[7])}}) && train_oe) else $error("preamble order");
  a_train_silent: assert property (@(posedge spi_clk) disable iff (cs_n || sys_rst)
    (c.s_work == PAT_RESET) |=> !train_oe) else $error("preamble with zero pattern");

  c_key_program: cover property (@(posedge clk) req_fire && p.op == SECRET_KEY_PROGRAM_CMD);
  c_stored_program: cover property (@(posedge clk) $rose(c.stored_done));
  c_lock_closed: cover property (@(posedge clk) $fell(c.lock));
  c_train_run: cover property (@(posedge spi_clk) train_oe [*4]);
endmodule // fsgtr_regs

/* verif/fsgtr_host.sv */
// SPI host model issuing register commands on the link
`timescale 1ns/1ps
module fsgtr_host (
  output logic spi_clk,
  output logic cs_n,
  output logic si,
  output logic ddr_dummy,
  input wire logic so,
  input wire logic so_oe,
  input wire logic [3:0] train_rise,
  input wire logic [3:0] train_fall,
  input wire logic train_oe
);
  initial begin
    spi_clk = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
    ddr_dummy = 1'b0;
  end
  // ********************************
  // Bit and frame timing
  // ********************************
  // Data set while low, so taken just before the rise
  task automatic tick(input logic b, output logic s);
    si = b;
    #3;
    // Released line reads back inverted
    s = so_oe ? so : !so;
    spi_clk = 1'b1;
    #3;
    spi_clk = 1'b0;
  endtask
  // One command per frame, select held well clear of the link edges
  task automatic frame(input logic [7:0] op, input logic [23:0] a, input int na,
      input logic [63:0] wd, input int nw, input int nr, output logic [63:0] rd);
    logic s;
    rd = 64'h0;
    cs_n = 1'b0;
    #200;
    for (int i = 7; i >= 0; i--) tick(op[i], s);
    for (int i = na - 1; i >= 0; i--) tick(a[i], s);
    for (int i = nw - 1; i >= 0; i--) tick(wd[i], s);
    for (int i = 0; i < nr; i++) begin
      tick(~si, s);
      rd = {rd[62:0], s};
    end
    #3;
    cs_n = 1'b1;
    si = ~si;
    #200;
  endtask
  // Dummy phase: {lines alike, oe any, oe all, bits seen}
  task automatic dummy(output logic [10:0] r);
    logic s;
    r = 11'h500;
    cs_n = 1'b0;
    #200;
    ddr_dummy = 1'b1;
    // Four link cycles carry one whole pattern, two bits each
    for (int i = 0; i < 4; i++) begin
      tick(1'b0, s);
      r[7:0] = {r[5:0], train_rise[0], train_fall[0]};
      r[9] = r[9] | train_oe;
      r[8] = r[8] & train_oe;
      r[10] = r[10] & (train_rise === {4{train_rise[0]}}) & (train_fall === {4{train_fall[0]}});
    end
    ddr_dummy = 1'b0;
    #3;
    cs_n = 1'b1;
    #200;
  endtask
endmodule // fsgtr_host

/* verif/flash_sector_guard_and_training_regs_tb.sv */
// Self-checking bench for the sector guard and training registers
`timescale 1ns/1ps
module flash_sector_guard_and_training_regs_tb
  import fsgtr_pkg::*;
;
  logic clk, sys_rst, hw_rst_n, sw_rst, spi_clk, cs_n, si, so, so_oe, ddr_dummy;
  logic [3:0] train_rise, train_fall;
  logic train_oe, secret_key_mode, persistent_mode, guard_array_writable;
  logic [SECTORS-1:0] sector_protect;
  logic [63:0] v;
  logic [10:0] tr;
  int error_cnt = 0;
  int check_count = 0;
  int cyc = 0;

  fsgtr_regs DUT (
    .clk(clk), .sys_rst(sys_rst), .hw_rst_n(hw_rst_n), .sw_rst(sw_rst),
    .spi_clk(spi_clk), .cs_n(cs_n), .si(si), .so(so), .so_oe(so_oe),
    .ddr_dummy(ddr_dummy), .train_rise(train_rise), .train_fall(train_fall),
    .train_oe(train_oe), .secret_key_mode(secret_key_mode),
    .persistent_mode(persistent_mode), .guard_array_writable(guard_array_writable),
    .sector_protect(sector_protect)
  );
  fsgtr_host u_host (
    .spi_clk(spi_clk), .cs_n(cs_n), .si(si), .ddr_dummy(ddr_dummy), .so(so), .so_oe(so_oe),
    .train_rise(train_rise), .train_fall(train_fall), .train_oe(train_oe)
  );

  // ********************************
  // Helpers
  // ********************************
  task automatic ck(input string w, input logic [63:0] e, input logic [63:0] g);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic rd(input logic [7:0] op, input logic [3:0] s, input int na, input int nr);
    u_host.frame(op, {4'h0, s, 16'h0000}, na, 64'h0, 0, nr, v);
  endtask
  task automatic wr(input logic [7:0] op, input logic [3:0] s, input int na,
      input logic [63:0] d, input int nw);
    u_host.frame(op, {4'h0, s, 16'h0000}, na, d, nw, 0, v);
  endtask
  task automatic pulse(input bit hw);
    @(posedge clk);
    if (hw) hw_rst_n <= 1'b0;
    else sw_rst <= 1'b1;
    repeat (4) @(posedge clk);
    hw_rst_n <= 1'b1;
    sw_rst <= 1'b0;
    repeat (6) @(posedge clk);
  endtask
  task automatic do_reset;
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (6) @(posedge clk);
  endtask
  task automatic conclude;
    $display("Checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // ********************************
  // Scenarios
  // ********************************
  task automatic t_defaults;
    rd(GUARD_LOCK_READ_CMD, 4'h0, 0, 8);
    ck("lock", 64'h01, v);
    rd(DYNAMIC_GUARD_READ_CMD, 4'h3, 24, 8);
    ck("dyn", 64'hff, v);
    rd(PERSISTENT_GUARD_READ_CMD, 4'h3, 24, 8);
    ck("pers", 64'hff, v);
    rd(TRAINING_PATTERN_READ_CMD, 4'h0, 0, 8);
    ck("pat", 64'h00, v);
    rd(SECRET_KEY_READ_CMD, 4'h0, 0, 64);
    ck("key", KEY_RESET, v);
    rd(CONFIG_WORD_READ_CMD, 4'h0, 0, 16);
    ck("cfg", 64'hffff, v);
    ck("flags", 19'h10000, {secret_key_mode, persistent_mode, guard_array_writable,
        sector_protect});
    $display("t_defaults done");
  endtask
  task automatic t_dynamic;
    wr(DYNAMIC_GUARD_WRITE_CMD, 4'h5, 24, 64'h00, 8);
    rd(DYNAMIC_GUARD_READ_CMD, 4'h5, 24, 8);
    ck("dyn5", 64'h00, v);
    rd(DYNAMIC_GUARD_READ_CMD, 4'h6, 24, 8);
    ck("dyn6", 64'hff, v);
    ck("prot", 16'h0020, sector_protect);
    pulse(1'b0);
    rd(DYNAMIC_GUARD_READ_CMD, 4'h5, 24, 8);
    ck("dyn rst", 64'hff, v);
    $display("t_dynamic done");
  endtask
  task automatic t_persist;
    wr(PERSISTENT_GUARD_PROGRAM_CMD, 4'h2, 24, 64'h0, 0);
    rd(PERSISTENT_GUARD_READ_CMD, 4'h2, 24, 8);
    ck("pers2", 64'h00, v);
    ck("prot", 16'h0004, sector_protect);
    wr(GUARD_LOCK_WRITE_CMD, 4'h0, 0, 64'hfe, 8);
    rd(GUARD_LOCK_READ_CMD, 4'h0, 0, 8);
    ck("lock", 64'h00, v);
    wr(PERSISTENT_GUARD_ERASE_CMD, 4'h0, 0, 64'h0, 0);
    pulse(1'b0);
    rd(PERSISTENT_GUARD_READ_CMD, 4'h2, 24, 8);
    ck("pers lk", 64'h00, v);
    ck("wr en", 64'h0, guard_array_writable);
    pulse(1'b1);
    wr(PERSISTENT_GUARD_ERASE_CMD, 4'h0, 0, 64'h0, 0);
    rd(PERSISTENT_GUARD_READ_CMD, 4'h2, 24, 8);
    ck("pers er", 64'hff, v);
    $display("t_persist done");
  endtask
  task automatic t_pattern;
    wr(WORKING_PATTERN_WRITE_CMD, 4'h0, 0, 64'h34, 8);
    rd(TRAINING_PATTERN_READ_CMD, 4'h0, 0, 8);
    ck("wpat", 64'h34, v);
    u_host.dummy(tr);
    ck("train", {3'b111, 8'h34}, tr);
    wr(STORED_PATTERN_PROGRAM_CMD, 4'h0, 0, 64'ha5, 8);
    rd(TRAINING_PATTERN_READ_CMD, 4'h0, 0, 8);
    ck("copy", 64'ha5, v);
    wr(WORKING_PATTERN_WRITE_CMD, 4'h0, 0, 64'h12, 8);
    pulse(1'b0);
    rd(TRAINING_PATTERN_READ_CMD, 4'h0, 0, 8);
    ck("reload", 64'ha5, v);
    wr(STORED_PATTERN_PROGRAM_CMD, 4'h0, 0, 64'h3c, 8);
    pulse(1'b0);
    rd(TRAINING_PATTERN_READ_CMD, 4'h0, 0, 8);
    ck("otp", 64'ha5, v);
    wr(WORKING_PATTERN_WRITE_CMD, 4'h0, 0, 64'h00, 8);
    u_host.dummy(tr);
    ck("no pre", {3'b100, 8'h00}, tr);
    $display("t_pattern done");
  endtask
  task automatic t_modes;
    do_reset();
    wr(SECRET_KEY_PROGRAM_CMD, 4'h0, 0, 64'h0123456789abcdef, 64);
    rd(SECRET_KEY_READ_CMD, 4'h0, 0, 64);
    ck("key", 64'h0123456789abcdef, v);
    wr(CONFIG_WORD_PROGRAM_CMD, 4'h0, 0, 64'hfffb, 16);
    ck("mode s", 2'b10, {secret_key_mode, persistent_mode});
    rd(CONFIG_WORD_READ_CMD, 4'h0, 0, 16);
    ck("cfg", 64'hfffb, v);
    rd(SECRET_KEY_READ_CMD, 4'h0, 0, 64);
    ck("hidden", KEY_RESET, v);
    do_reset();
    wr(CONFIG_WORD_PROGRAM_CMD, 4'h0, 0, 64'hfffd, 16);
    ck("mode p", 2'b01, {secret_key_mode, persistent_mode});
    $display("t_modes done");
  endtask

  // ********************************
  // Clock, watchdog and main sequence
  // ********************************
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      $display("[FAIL] watchdog expected finish seen hang");
      conclude();
    end
  end
  initial begin
    sys_rst = 1'b1;
    hw_rst_n = 1'b1;
    sw_rst = 1'b0;
    do_reset();
    t_defaults();
    t_dynamic();
    t_persist();
    t_pattern();
    t_modes();
    conclude();
  end
endmodule // flash_sector_guard_and_training_regs_tb
